// [src/dual_adc_output_power_control.v]
// Top of the dual converter output control: pins, two channels, port swap and Avalon-MM registers
//
// Function
// - Output disable high floats channel data and flag
// - Each channel has its own output disable
// - Power down low converts normally
// - Power down and disable high gives sleep
// - Data invalid for milliseconds after sleep
// - Power down high, disable low gives nap
// - Nap recovery takes about 100 sample clocks
// - Nap or sleep floats that channel's outputs only
// - Each channel's power mode governed by own pins only
// - Swap high: A on first port
// - Swap low: A on second port
// - Overrange flag high outside convertible range
// - Upper format levels give two's complement
`timescale 1ns/1ns
`include "dual_adc_defines.vh"
module dual_adc_output_power_control #(
   parameter NAP_SAMPLES = `NAP_RECOVER_SAMPLES,
   parameter SLEEP_CYCLES = `SLEEP_RECOVER_CYCLES,
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Channel control pins
   input wire chan_a_output_hiz_n_i,
   input wire chan_b_output_hiz_n_i,
   input wire chan_a_power_down_i,
   input wire chan_b_power_down_i,
   input wire port_swap_sel_i,
   input wire [1:0] format_sel_i,
   // Sample clocks, sampled as levels
   input wire chan_a_sample_clock_i,
   input wire chan_b_sample_clock_i,
   // Converter core results
   input wire [`WORD_W-1:0] chan_a_code_i,
   input wire chan_a_out_of_range_i,
   input wire [`WORD_W-1:0] chan_b_code_i,
   input wire chan_b_out_of_range_i,
   // First output port
   output reg [`WORD_W-1:0] first_port_word_o,
   output reg first_port_word_oe_o,
   output reg first_port_overrange_o,
   output reg first_port_overrange_oe_o,
   // Second output port
   output reg [`WORD_W-1:0] second_port_word_o,
   output reg second_port_word_oe_o,
   output reg second_port_overrange_o,
   output reg second_port_overrange_oe_o,
   // Avalon-MM slave
   input wire [4:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // Interrupt
   output reg irq_o
);

   // ==========================================================
   // Synchronised pins
   // Eleven single pins plus two code words
   localparam PIN_W = 2 * `WORD_W + 11;

   // Raw and synced bundles
   wire [PIN_W-1:0] pins_async;
   wire [PIN_W-1:0] pins_sync;

   // Synced levels, one name per pin
   wire a_hiz_n;
   wire b_hiz_n;
   wire a_pd;
   wire b_pd;
   wire swap;
   wire [1:0] fmt;
   wire a_sclk;
   wire b_sclk;
   wire a_oor;
   wire b_oor;
   wire [`WORD_W-1:0] a_code;
   wire [`WORD_W-1:0] b_code;

   // Pack order must match the unpack below
   assign pins_async = {chan_a_output_hiz_n_i, chan_b_output_hiz_n_i, chan_a_power_down_i,
                        chan_b_power_down_i, port_swap_sel_i, format_sel_i, chan_a_sample_clock_i,
                        chan_b_sample_clock_i, chan_a_out_of_range_i, chan_b_out_of_range_i,
                        chan_a_code_i, chan_b_code_i};
   assign {a_hiz_n, b_hiz_n, a_pd, b_pd, swap, fmt, a_sclk, b_sclk, a_oor, b_oor, a_code, b_code} = pins_sync;

   // Codes share flops with the sample clocks, so a code
   // and the edge that captures it arrive together
   pin_sync #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .async_i(pins_async),
      .sync_o(pins_sync)
   );

   // ==========================================================
   // Registers
   // Sticky status; enable and control are read-write
   reg [`EVT_W-1:0] status;
   reg [`EVT_W-1:0] irq_en;
   reg [`CTRL_W-1:0] ctrl;

   // Event pulses and the shared format flag
   wire [`EVT_W-1:0] events;
   wire twos_comp;

   // Format pin levels 2 and 3 select two's complement for both channels
   assign twos_comp = fmt[1];

   // ==========================================================
   // Two channels, each fed by its own pins plus the shared format pins and blanking control
   // Captured words and flags
   wire [`WORD_W-1:0] a_word;
   wire [`WORD_W-1:0] b_word;
   wire a_ovr;
   wire b_ovr;

   // Drive enables and power states
   wire a_drive;
   wire b_drive;
   wire [`ST_W-1:0] a_state;
   wire [`ST_W-1:0] b_state;

   // One-cycle event pulses
   wire a_rec;
   wire b_rec;
   wire a_ovr_evt;
   wire b_ovr_evt;
   wire a_pwr_evt;
   wire b_pwr_evt;

   // Channel A
   chan_power_ctrl #(
      .NAP_SAMPLES(NAP_SAMPLES),
      .SLEEP_CYCLES(SLEEP_CYCLES),
      .CNT_W(CNT_W)
   ) u_chan_a (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .sample_clk_i(a_sclk),
      .power_down_i(a_pd),
      .output_hiz_n_i(a_hiz_n),
      .twos_comp_i(twos_comp),
      .blank_recover_i(ctrl[`CTRL_BLANK_RECOVER]),
      .code_i(a_code),
      .out_of_range_i(a_oor),
      .word_o(a_word),
      .overrange_o(a_ovr),
      .drive_o(a_drive),
      .state_o(a_state),
      .recovered_o(a_rec),
      .overrange_evt_o(a_ovr_evt),
      .pwr_change_o(a_pwr_evt)
   );

   // Channel B
   chan_power_ctrl #(
      .NAP_SAMPLES(NAP_SAMPLES),
      .SLEEP_CYCLES(SLEEP_CYCLES),
      .CNT_W(CNT_W)
   ) u_chan_b (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .sample_clk_i(b_sclk),
      .power_down_i(b_pd),
      .output_hiz_n_i(b_hiz_n),
      .twos_comp_i(twos_comp),
      .blank_recover_i(ctrl[`CTRL_BLANK_RECOVER]),
      .code_i(b_code),
      .out_of_range_i(b_oor),
      .word_o(b_word),
      .overrange_o(b_ovr),
      .drive_o(b_drive),
      .state_o(b_state),
      .recovered_o(b_rec),
      .overrange_evt_o(b_ovr_evt),
      .pwr_change_o(b_pwr_evt)
   );

   // ==========================================================
   // Port swap; tying swap to the sample clock alternates channels each half period
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         first_port_word_o <= {`WORD_W{1'b0}};
         first_port_word_oe_o <= 1'b0;
         first_port_overrange_o <= 1'b0;
         first_port_overrange_oe_o <= 1'b0;
         second_port_word_o <= {`WORD_W{1'b0}};
         second_port_word_oe_o <= 1'b0;
         second_port_overrange_o <= 1'b0;
         second_port_overrange_oe_o <= 1'b0;
      end else if (swap) begin
         // Channel A leads on the first port
         first_port_word_o <= a_word;
         first_port_overrange_o <= a_ovr;
         first_port_word_oe_o <= a_drive;
         first_port_overrange_oe_o <= a_drive;
         second_port_word_o <= b_word;
         second_port_overrange_o <= b_ovr;
         second_port_word_oe_o <= b_drive;
         second_port_overrange_oe_o <= b_drive;
      end else begin
         // Ports exchanged: channel B leads
         first_port_word_o <= b_word;
         first_port_overrange_o <= b_ovr;
         first_port_word_oe_o <= b_drive;
         first_port_overrange_oe_o <= b_drive;
         second_port_word_o <= a_word;
         second_port_overrange_o <= a_ovr;
         second_port_word_oe_o <= a_drive;
         second_port_overrange_oe_o <= a_drive;
      end
   end

   // ==========================================================
   // Bus handshake: one wait cycle, then a single-cycle acknowledge
   wire access;
   wire take;

   assign access = avs_read_i | avs_write_i;
   assign take = access & ~avs_waitrequest_o;

   // A request still held at its acknowledge edge sees
   // waitrequest high again, so it cannot complete twice
   always @(posedge sys_clk_i) begin
      if (srst_i)
         avs_waitrequest_o <= 1'b1;
      else if (access && avs_waitrequest_o)
         avs_waitrequest_o <= 1'b0;
      else
         avs_waitrequest_o <= 1'b1;
   end

   // Read data is prepared while waitrequest is dropped; unmapped offsets read zero
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         case (avs_address_i)
            {1'b0, `REG_STATUS}: avs_readdata_o <= {{(32-`EVT_W){1'b0}}, status};
            {1'b0, `REG_IRQ_EN}: avs_readdata_o <= {{(32-`EVT_W){1'b0}}, irq_en};
            {1'b0, `REG_CTRL}: avs_readdata_o <= {{(32-`CTRL_W){1'b0}}, ctrl};
            `REG_CHAN_STATE_ADDR: avs_readdata_o <= {22'h00_0000, fmt, b_state, a_state};
            default: avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Writes take effect at the acknowledge edge, low byte lane only
   wire wr_low;

   assign wr_low = take & avs_write_i & avs_byteenable_i[0];

   // Only enable and control are writable
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_en <= {`EVT_W{1'b0}};
         ctrl <= `CTRL_RESET;
      end else if (wr_low) begin
         if (avs_address_i == {1'b0, `REG_IRQ_EN})
            irq_en <= avs_writedata_i[`EVT_W-1:0];
         if (avs_address_i == {1'b0, `REG_CTRL})
            ctrl <= avs_writedata_i[`CTRL_W-1:0];
      end
   end

   // ==========================================================
   // Sticky events; a new event beats a clear in the same cycle
   assign events = {b_pwr_evt, a_pwr_evt, b_rec, a_rec, b_ovr_evt, a_ovr_evt};

   // Clear mask from a write to the clear register
   wire [`EVT_W-1:0] clr;

   assign clr = (wr_low && avs_address_i == {1'b0, `REG_IRQ_CLR}) ? avs_writedata_i[`EVT_W-1:0]
                                                                 : {`EVT_W{1'b0}};

   // Interrupt uses the next status, so it changes on the same clock as status
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         status <= {`EVT_W{1'b0}};
         irq_o <= 1'b0;
      end else begin
         status <= (status & ~clr) | events;
         irq_o <= |(((status & ~clr) | events) & irq_en);
      end
   end

endmodule // dual_adc_output_power_control

// [src/dual_adc_defines.vh]
// Shared offsets, field positions, reset values and timing counts for the dual converter output control
`ifndef DUAL_ADC_DEFINES_VH
`define DUAL_ADC_DEFINES_VH

// ==========================================================
// Register byte offsets (word aligned)
`define REG_STATUS 4'h0
`define REG_IRQ_EN 4'h4
`define REG_IRQ_CLR 4'h8
`define REG_CTRL 4'hc
`define REG_CHAN_STATE 4'h0
`define REG_ADDR_W 4

// ==========================================================
// Register offsets above the low nibble live in a second range
`define REG_CHAN_STATE_ADDR 5'h10

// ==========================================================
// Status, enable and clear bit positions
`define EVT_A_OVERRANGE 0
`define EVT_B_OVERRANGE 1
`define EVT_A_RECOVERED 2
`define EVT_B_RECOVERED 3
`define EVT_A_PWR_CHANGE 4
`define EVT_B_PWR_CHANGE 5
`define EVT_W 6

// ==========================================================
// Control register fields and reset value
`define CTRL_BLANK_RECOVER 0
`define CTRL_W 1
`define CTRL_RESET 1'h1

// ==========================================================
// Channel state codes, one-hot
`define ST_NORMAL 4'h1
`define ST_NAP 4'h2
`define ST_SLEEP 4'h4
`define ST_RECOVER 4'h8
`define ST_W 4

// ==========================================================
// Timing: clock rate, nap recovery in sample clocks, sleep recovery time
`define SYS_CLK_HZ 25000000
`define NAP_RECOVER_SAMPLES 100
`define SLEEP_RECOVER_US 2000
`define SLEEP_RECOVER_CYCLES ((`SLEEP_RECOVER_US * (`SYS_CLK_HZ / 1000000)))

// ==========================================================
// Data widths
`define WORD_W 10

`endif

// [src/pin_sync.v]
// Two flip-flop synchroniser for a group of level inputs from outside the clock domain
`timescale 1ns/1ns
module pin_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] async_i,
   output reg [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta;

   // ==========================================================
   // First stage feeds only the second stage
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         meta <= {WIDTH{1'b0}};
         sync_o <= {WIDTH{1'b0}};
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule // pin_sync

// [src/chan_power_ctrl.v]
// One converter channel: power mode, recovery blanking, output word capture and drive enable
`timescale 1ns/1ns
`include "dual_adc_defines.vh"
module chan_power_ctrl #(
   parameter NAP_SAMPLES = `NAP_RECOVER_SAMPLES,
   parameter SLEEP_CYCLES = `SLEEP_RECOVER_CYCLES,
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Synchronised pin levels and blanking control
   input wire sample_clk_i,
   input wire power_down_i,
   input wire output_hiz_n_i,
   input wire twos_comp_i,
   input wire blank_recover_i,
   // Converter core result
   input wire [`WORD_W-1:0] code_i,
   input wire out_of_range_i,
   // Channel outputs
   output reg [`WORD_W-1:0] word_o,
   output reg overrange_o,
   output reg drive_o,
   output reg [`ST_W-1:0] state_o,
   output reg recovered_o,
   output reg overrange_evt_o,
   output reg pwr_change_o
);

   reg sample_d;
   reg from_sleep;
   reg [CNT_W-1:0] count;
   reg [`ST_W-1:0] next_state;
   wire sample_edge;

   assign sample_edge = sample_clk_i & ~sample_d;

   // ==========================================================
   // Power mode selection from this channel's own pins only
   always @* begin
      next_state = state_o;
      if (power_down_i) begin
         if (output_hiz_n_i)
            next_state = `ST_SLEEP;
         else
            next_state = `ST_NAP;
      end else begin
         case (state_o)
            `ST_NAP: next_state = `ST_RECOVER;
            `ST_SLEEP: next_state = `ST_RECOVER;
            `ST_RECOVER: begin
               if ((from_sleep && count == SLEEP_CYCLES[CNT_W-1:0] - 1'b1) ||
                   (!from_sleep && sample_edge && count == NAP_SAMPLES[CNT_W-1:0] - 1'b1))
                  next_state = `ST_NORMAL;
            end
            `ST_NORMAL: next_state = `ST_NORMAL;
            default: next_state = `ST_NORMAL;
         endcase
      end
   end

   // ==========================================================
   // State, recovery counter and output word; the word only moves on a sample edge
   always @(posedge sys_clk_i) begin
      if (srst_i) begin
         sample_d <= 1'b0;
         state_o <= `ST_NORMAL;
         from_sleep <= 1'b0;
         count <= {CNT_W{1'b0}};
         word_o <= {`WORD_W{1'b0}};
         overrange_o <= 1'b0;
         drive_o <= 1'b0;
         recovered_o <= 1'b0;
         overrange_evt_o <= 1'b0;
         pwr_change_o <= 1'b0;
      end else begin
         sample_d <= sample_clk_i;
         state_o <= next_state;
         recovered_o <= (state_o == `ST_RECOVER) && (next_state == `ST_NORMAL);
         pwr_change_o <= (next_state != state_o);
         overrange_evt_o <= 1'b0;
         if (state_o == `ST_SLEEP)
            from_sleep <= 1'b1;
         else if (state_o == `ST_NAP)
            from_sleep <= 1'b0;
         // Sleep recovery counts system clocks, nap recovery counts sample clocks
         if (state_o != `ST_RECOVER)
            count <= {CNT_W{1'b0}};
         else if (from_sleep || sample_edge)
            count <= count + 1'b1;
         // Nap and sleep float the pins whatever the disable pin says
         drive_o <= ~output_hiz_n_i && (next_state == `ST_NORMAL || next_state == `ST_RECOVER);
         if (sample_edge && (state_o == `ST_NORMAL || state_o == `ST_RECOVER)) begin
            if (state_o == `ST_RECOVER && blank_recover_i) begin
               word_o <= {`WORD_W{1'b0}};
               overrange_o <= 1'b0;
            end else begin
               // Upper format levels flip the sign bit for two's complement
               word_o <= {code_i[`WORD_W-1] ^ twos_comp_i, code_i[`WORD_W-2:0]};
               overrange_o <= out_of_range_i;
               overrange_evt_o <= out_of_range_i;
            end
         end
      end
   end

endmodule // chan_power_ctrl

// [src/_unused_guard_note.v]
// Empty unit: the block needs no further module

// [tb/dual_adc_output_power_control_monitor.sv]
// Port-level assertions for the dual converter output control
`timescale 1ns/1ns
module dual_adc_output_power_control_monitor #(
   parameter NAP_SAMPLES = 100,
   parameter SLEEP_CYCLES = 50000,
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire sys_clk_i,
   input wire srst_i,
   // Channel pins
   input wire chan_a_output_hiz_n_i,
   input wire chan_b_output_hiz_n_i,
   input wire chan_a_power_down_i,
   input wire port_swap_sel_i,
   // Port enables
   input wire first_port_word_oe_o,
   input wire first_port_overrange_oe_o,
   input wire second_port_word_oe_o,
   // Bus handshake
   input wire avs_read_i,
   input wire avs_write_i,
   input wire avs_waitrequest_o
);
   // ==========================================================
   // Pin checks wait eight edges: two sync flops, state and port register
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);
   a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("no answer one cycle after a request");
   a_wait_single: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
      else $error("answer without a request");
   a_flag_float_pair: assert property (first_port_word_oe_o == first_port_overrange_oe_o)
      else $error("word and flag enables differ");
   a_hiz_first_port: assert property ((chan_a_output_hiz_n_i && port_swap_sel_i) [*8] |-> !first_port_word_oe_o)
      else $error("disabled channel still drives");
   a_hiz_other_port: assert property ((chan_b_output_hiz_n_i && port_swap_sel_i) [*8] |-> !second_port_word_oe_o)
      else $error("disabled channel still drives");
   a_nap_floats: assert property ((chan_a_power_down_i && port_swap_sel_i) [*8] |-> !first_port_word_oe_o)
      else $error("powered down channel still drives");
   a_run_drives: assert property ((!chan_a_output_hiz_n_i && !chan_a_power_down_i && port_swap_sel_i) [*8]
      |-> first_port_word_oe_o)
      else $error("running channel not driven");
endmodule // dual_adc_output_power_control_monitor

bind dual_adc_output_power_control dual_adc_output_power_control_monitor #(
   .NAP_SAMPLES(NAP_SAMPLES), .SLEEP_CYCLES(SLEEP_CYCLES), .CNT_W(CNT_W)
) monitor (
   .sys_clk_i(sys_clk_i), .srst_i(srst_i), .chan_a_output_hiz_n_i(chan_a_output_hiz_n_i),
   .chan_b_output_hiz_n_i(chan_b_output_hiz_n_i), .chan_a_power_down_i(chan_a_power_down_i),
   .port_swap_sel_i(port_swap_sel_i), .first_port_word_oe_o(first_port_word_oe_o),
   .first_port_overrange_oe_o(first_port_overrange_oe_o), .second_port_word_oe_o(second_port_word_oe_o),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o)
);

// [tb/port_capture_model.sv]
// Capturing logic on one output port: resolves the floating lines and takes words on request
`timescale 1ns/1ns
module port_capture_model (
   // Clock
   input wire sys_clk_i,
   // Port lines from the converter
   input wire [9:0] word_i,
   input wire word_oe_i,
   input wire flag_i,
   input wire flag_oe_i,
   // Capture strobe and recovery blanking
   input wire capture_i,
   input wire discard_i,
   // Last accepted flag and word
   output reg [10:0] sample_o
);
   reg [10:0] last = 11'h000;
   wire [10:0] lvl;
   // A released line shows the inverse of its last level, so a float never matches
   assign lvl = {flag_oe_i ? flag_i : ~last[10], word_oe_i ? word_i : ~last[9:0]};
   // Words offered while the converter recovers are dropped
   always @(posedge sys_clk_i) begin
      last <= lvl;
      if (capture_i && !discard_i)
         sample_o <= lvl;
   end
endmodule // port_capture_model

// [tb/dual_adc_output_power_control_tb_top.sv]
// Self-checking bench: pin modes, port mapping, formats, interleave and registers
`timescale 1ns/1ns
`include "dual_adc_defines.vh"
module dual_adc_output_power_control_tb_top;
   // ==========================================================
   // Stimulus and observation
   localparam HP = 8;
   reg clk = 1'h0, srst = 1'h1, hiz_a = 1'h0, hiz_b = 1'h0, pd_a = 1'h0, pd_b = 1'h0, swp = 1'h1, ilv = 1'h0;
   reg samp = 1'h0, oor_a = 1'h0, oor_b = 1'h0, rd = 1'h0, wr = 1'h0, cap = 1'h0, disc = 1'h0, s;
   reg [1:0] fmt = 2'h0;
   reg [3:0] ph = 4'h0;
   reg [4:0] addr = 5'h00;
   reg [9:0] code_a = 10'h000, code_b = 10'h000;
   reg [31:0] wdata = 32'h0, rdata;
   wire [9:0] w1, w2;
   wire oe1, f1, foe1, oe2, f2, foe2, wreq, irq;
   wire [31:0] rdat;
   wire [10:0] got;
   integer fail_count = 0, samples_checked = 0, i, n;

   // System clock, 40 ns period
   always #20 clk = ~clk;
   // Shared sample clock, HP system clocks a phase
   always @(posedge clk) begin
      ph <= (ph == HP - 1) ? 4'h0 : ph + 4'h1;
      if (ph == HP - 1)
         samp <= ~samp;
   end

   // Interleave ties the swap pin to the sample clock of both channels
   dual_adc_output_power_control #(.NAP_SAMPLES(5), .SLEEP_CYCLES(20), .CNT_W(16)) dut (
      .sys_clk_i(clk), .srst_i(srst), .chan_a_output_hiz_n_i(hiz_a), .chan_b_output_hiz_n_i(hiz_b),
      .chan_a_power_down_i(pd_a), .chan_b_power_down_i(pd_b), .port_swap_sel_i(ilv ? samp : swp),
      .format_sel_i(fmt), .chan_a_sample_clock_i(samp), .chan_b_sample_clock_i(samp),
      .chan_a_code_i(code_a), .chan_a_out_of_range_i(oor_a), .chan_b_code_i(code_b),
      .chan_b_out_of_range_i(oor_b), .first_port_word_o(w1), .first_port_word_oe_o(oe1),
      .first_port_overrange_o(f1), .first_port_overrange_oe_o(foe1), .second_port_word_o(w2),
      .second_port_word_oe_o(oe2), .second_port_overrange_o(f2), .second_port_overrange_oe_o(foe2),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq));
   // Only the first port is read while interleaving
   port_capture_model model (.sys_clk_i(clk), .word_i(w1), .word_oe_i(oe1), .flag_i(f1), .flag_oe_i(foe1),
      .capture_i(cap), .discard_i(disc), .sample_o(got));

   // ==========================================================
   // Expected port content of one channel in the current format
   function [12:0] pexp(input sel_a);
      reg [9:0] c;
      begin
         c = sel_a ? code_a : code_b;
         pexp = {2'h3, sel_a ? oor_a : oor_b, fmt[1] ? c ^ 10'h200 : c};
      end
   endfunction
   function [31:0] cs(input [3:0] a, input [3:0] b);
      cs = {22'h0, fmt, b, a};
   endfunction
   task check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task stall;
      begin
         fail_count = fail_count + 1;
         results;
      end
   endtask
   // One Avalon-MM transfer, request held until waitrequest is seen low
   task bus(input w, input [4:0] a, input [31:0] d);
      integer k;
      begin
         addr <= a;
         wdata <= d;
         rd <= ~w;
         wr <= w;
         k = 0;
         @(posedge clk);
         while (wreq !== 1'h0) begin
            @(posedge clk);
            k = k + 1;
            if (k > 20)
               stall;
         end
         rdata = rdat;
         rd <= 1'h0;
         wr <= 1'h0;
         @(posedge clk);
      end
   endtask
   task rchk(input [4:0] a, input [31:0] e);
      begin
         bus(1'h0, a, 32'h0);
         check(rdata, e);
      end
   endtask
   task wstate(input [31:0] e, input integer tries);
      integer j;
      begin
         bus(1'h0, `REG_CHAN_STATE_ADDR, 32'h0);
         for (j = 0; j < tries && rdata !== e; j = j + 1)
            bus(1'h0, `REG_CHAN_STATE_ADDR, 32'h0);
         check(rdata, e);
         if (rdata !== e)
            results;
      end
   endtask

   // Watchdog against a hang anywhere in the sequence
   initial begin
      repeat (40000) @(posedge clk);
      stall;
   end

   // ==========================================================
   // Main sequence; disable pins change only between runs, never per sample
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      rchk(`REG_CTRL, 32'h1);
      rchk(`REG_STATUS, 32'h0);
      rchk(`REG_CHAN_STATE_ADDR, cs(`ST_NORMAL, `ST_NORMAL));
      bus(1'h1, 5'h14, 32'hffffffff);
      rchk(5'h14, 32'h0);
      bus(1'h1, `REG_IRQ_EN, 32'h3f);
      rchk(`REG_IRQ_EN, 32'h3f);
      rchk(`REG_IRQ_CLR, 32'h0);
      bus(1'h1, `REG_IRQ_EN, 32'h0);
      $display("test registers done");
      // Every format level under both swap settings, fresh codes each pass
      for (i = 0; i < 8; i = i + 1) begin
         fmt <= i[2:1];
         swp <= i[0];
         code_a <= 10'h2a5 + i[9:0];
         code_b <= 10'h15a - i[9:0];
         oor_a <= i[1];
         oor_b <= ~i[1];
         repeat (6 * HP) @(posedge clk);
         check({oe1, foe1, f1, w1}, pexp(swp));
         check({oe2, foe2, f2, w2}, pexp(~swp));
      end
      $display("test mapping done");
      // Overrange events: sticky, masked, enabled, cleared
      oor_a <= 1'h0;
      oor_b <= 1'h0;
      fmt <= 2'h0;
      swp <= 1'h1;
      repeat (6 * HP) @(posedge clk);
      rchk(`REG_STATUS, 32'h3);
      check(irq, 1'h0);
      bus(1'h1, `REG_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk);
      check(irq, 1'h1);
      bus(1'h1, `REG_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clk);
      check(irq, 1'h0);
      rchk(`REG_STATUS, 32'h2);
      bus(1'h1, `REG_IRQ_CLR, 32'h3f);
      $display("test interrupt done");
      // Output disable alone floats channel A and keeps it converting
      hiz_a <= 1'h1;
      repeat (12) @(posedge clk);
      check({oe1, foe1, oe2}, 3'h1);
      rchk(`REG_CHAN_STATE_ADDR, cs(`ST_NORMAL, `ST_NORMAL));
      hiz_a <= 1'h0;
      // Nap on A, recovery blanked and bounded
      pd_a <= 1'h1;
      repeat (12) @(posedge clk);
      check({oe1, foe1, oe2}, 3'h1);
      rchk(`REG_CHAN_STATE_ADDR, cs(`ST_NAP, `ST_NORMAL));
      pd_a <= 1'h0;
      disc <= 1'h1;
      repeat (24) @(posedge clk);
      check({oe1, w1}, 11'h400);
      rchk(`REG_CHAN_STATE_ADDR, cs(`ST_RECOVER, `ST_NORMAL));
      wstate(cs(`ST_NORMAL, `ST_NORMAL), 40);
      rchk(`REG_STATUS, 32'h14);
      bus(1'h1, `REG_IRQ_CLR, 32'h3f);
      // Sleep on B while A keeps driving; recovery words unblanked
      bus(1'h1, `REG_CTRL, 32'h0);
      rchk(`REG_CTRL, 32'h0);
      hiz_b <= 1'h1;
      pd_b <= 1'h1;
      repeat (12) @(posedge clk);
      check({oe1, oe2, foe2}, 3'h4);
      rchk(`REG_CHAN_STATE_ADDR, cs(`ST_NORMAL, `ST_SLEEP));
      hiz_b <= 1'h0;
      pd_b <= 1'h0;
      code_b <= 10'h1c3;
      repeat (6) @(posedge clk);
      rchk(`REG_CHAN_STATE_ADDR, cs(`ST_NORMAL, `ST_RECOVER));
      repeat (12) @(posedge clk);
      check({oe2, w2}, 11'h5c3);
      wstate(cs(`ST_NORMAL, `ST_NORMAL), 20);
      rchk(`REG_STATUS, 32'h28);
      disc <= 1'h0;
      $display("test power modes done");
      // Interleave: each phase of the shared clock carries one channel
      ilv <= 1'h1;
      code_a <= 10'h0f0;
      code_b <= 10'h30c;
      oor_b <= 1'h1;
      repeat (6 * HP) @(posedge clk);
      for (i = 0; i < 4; i = i + 1) begin
         s = samp;
         for (n = 0; samp === s; n = n + 1) begin
            @(posedge clk);
            if (n > 40)
               stall;
         end
         cap <= 1'h1;
         @(posedge clk);
         cap <= 1'h0;
         @(posedge clk);
         check(got, pexp(s) & 13'h7ff);
      end
      $display("test interleave done");
      results;
   end
endmodule // dual_adc_output_power_control_tb_top
